// File: rtl/sdc_cmd_buffer.sv
// Purpose: Two-entry buffer for accepted command words
// Assumes: Same clock as the frame port; reads come from registers
// Notes:   Full and empty are exact; ready drops only when both are held
`timescale 1ns/10ps
`default_nettype none
module sdc_cmd_buffer
  import sdc_pkg::*;
#(
  parameter int WIDTH = SDC_WORD_BITS
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  sdc_stream_if.snk in_s,
  sdc_stream_if.src out_s
);
  logic [WIDTH-1:0] mem_reg [SDC_BUF_DEPTH];
  logic [WIDTH-1:0] mem_next [SDC_BUF_DEPTH];
  logic [1:0]       fill_reg;
  logic [1:0]       fill_next;
  logic             push;
  logic             pop;

  // Entry 0 is the head; a pop slides entry 1 down
  assign in_s.ready  = (fill_reg != 2'h2);
  assign out_s.valid = (fill_reg != 2'h0);
  assign out_s.data  = mem_reg[0];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  // Next contents and fill level
  always_comb begin
    mem_next[0] = mem_reg[0];
    mem_next[1] = mem_reg[1];
    fill_next   = fill_reg;
    if (pop) begin
      mem_next[0] = mem_reg[1];
    end
    if (push) begin
      if (fill_reg == 2'h0 || (fill_reg == 2'h1 && pop)) begin
        mem_next[0] = in_s.data;
      end else begin
        mem_next[pop ? 0 : fill_reg[0]] = in_s.data;
      end
    end
    if (push && !pop) begin
      fill_next = fill_reg + 2'h1;
    end else if (pop && !push) begin
      fill_next = fill_reg - 2'h1;
    end
  end

  // Storage registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      fill_reg   <= 2'h0;
    end else begin
      mem_reg[0] <= mem_next[0];
      mem_reg[1] <= mem_next[1];
      fill_reg   <= fill_next;
    end
  end
endmodule
`default_nettype wire

// File: rtl/sdc_frame_port.sv
// Purpose: Device end of a daisy-chainable 16-bit serial control port
// Assumes: Pins are sampled by core_clk (100 MHz) after two flip-flops
// Notes:   Samples serial input on clock rise, updates output on fall
//
// Notes on behaviour
// - With select low and no clock edges, output holds warning level.
// - Each of the first fifteen serial clocks in a frame shifts the next status bit out.
// - The first sixteen bits out after select falls are the status word.
// - Serial input passes through to serial output, sixteen bits later.
// - Data is accepted only while this device's select input is low.
// - On select falling, warning status bit drives the output at once.
// - Output low means no warning latched, high means warning latched.
// - Latched warning clears only on a good frame with reset request set.
`timescale 1ns/10ps
`default_nettype none
module sdc_frame_port
  import sdc_pkg::*;
#(
  parameter int WIDTH = SDC_WORD_BITS
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             select_bar_in,
  input  wire logic             sclk_in,
  input  wire logic             sdata_in,
  output logic                  sdata_out,
  output logic                  sdata_oe,
  input  wire logic             warn_level_in,
  input  wire logic [WIDTH-1:0] diag_status_in,
  output logic                  thermal_warning_flag,
  output logic [WIDTH-1:0]      cfg_word,
  output logic                  cmd_valid,
  input  wire logic             cmd_ready,
  output logic [WIDTH-1:0]      cmd_data,
  output logic                  cmd_overrun
);
  sdc_stream_if #(.WIDTH(WIDTH)) push_s ();
  sdc_stream_if #(.WIDTH(WIDTH)) pop_s ();

  logic [3:0]     sync1_reg;
  logic [3:0]     sync2_reg;
  logic           cs_d_reg;
  logic           sck_d_reg;
  logic           cs_n;
  logic           sck;
  logic           si;
  logic           warn;
  logic           cs_fall;
  logic           cs_rise;
  logic           sck_rise;
  logic           sck_fall;
  sdc_state_t     state_reg;
  sdc_state_t     state_next;
  logic [WIDTH-1:0] sh_reg;
  logic [WIDTH-1:0] sh_next;
  logic [SDC_CNT_W-1:0] cnt_reg;
  logic [SDC_CNT_W-1:0] cnt_next;
  logic           any_reg;
  logic           any_next;
  logic           so_reg;
  logic           so_next;
  logic           flag_reg;
  logic           flag_next;
  logic [WIDTH-1:0] cfg_reg;
  logic [WIDTH-1:0] cfg_next;
  logic [WIDTH-1:0] pend_reg;
  logic [WIDTH-1:0] pend_next;
  logic           pend_v_reg;
  logic           pend_v_next;
  logic           ovr_reg;
  logic           ovr_next;
  logic           commit;

  // Two-stage synchronisers; first stage feeds only the second
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 4'b0001;  // Select idles high (deselected)
      sync2_reg <= 4'b0001;
      cs_d_reg  <= 1'b1;
      sck_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {warn_level_in, sdata_in, sclk_in, select_bar_in};
      sync2_reg <= sync1_reg;
      cs_d_reg  <= sync2_reg[0];
      sck_d_reg <= sync2_reg[1];
    end
  end

  // Synchronised levels and their edges
  assign cs_n     = sync2_reg[0];
  assign sck      = sync2_reg[1];
  assign si       = sync2_reg[2];
  assign warn     = sync2_reg[3];
  assign cs_fall  = cs_d_reg & ~cs_n;
  assign cs_rise  = ~cs_d_reg & cs_n;
  assign sck_rise = ~sck_d_reg & sck;
  assign sck_fall = sck_d_reg & ~sck;

  // Frame is kept only when a whole number of words was clocked
  assign commit = (state_reg == SDC_ST_SHIFT) && cs_rise && any_reg
                  && (cnt_reg == SDC_CNT_RESET);

  // Frame sequencer, shifter and output bit
  always_comb begin
    state_next = state_reg;
    sh_next    = sh_reg;
    cnt_next   = cnt_reg;
    any_next   = any_reg;
    so_next    = so_reg;
    case (state_reg)
      SDC_ST_IDLE: begin
        so_next = 1'b0;
        if (cs_fall) begin
          state_next = SDC_ST_SHIFT;
          // Status word loaded, bit 0 is the warning flag
          sh_next    = {diag_status_in[WIDTH-1:1], flag_reg};
          so_next    = flag_reg;  // Shown with no clock edge
          cnt_next   = SDC_CNT_RESET;
          any_next   = 1'b0;
        end
      end
      SDC_ST_SHIFT: begin
        if (cs_rise) begin
          // Edges in the release cycle are ignored
          state_next = SDC_ST_IDLE;
          so_next    = 1'b0;
        end else if (sck_rise) begin
          // Input enters at the top, reaches output after 16 bits
          sh_next  = {si, sh_reg[WIDTH-1:1]};
          cnt_next = cnt_reg + SDC_CNT_ONE;
          any_next = 1'b1;
        end else if (sck_fall) begin
          so_next = sh_reg[0];  // Next bit out on each clock
        end
        // Level held while clock rests either way
      end
      default: begin
        state_next = SDC_ST_IDLE;
        so_next    = 1'b0;
      end
    endcase
  end

  // Warning latch, configuration and pending command word
  always_comb begin
    flag_next   = flag_reg;
    cfg_next    = cfg_reg;
    pend_next   = pend_reg;
    pend_v_next = pend_v_reg & ~push_s.ready;
    ovr_next    = 1'b0;
    if (commit) begin
      cfg_next    = sh_reg;  // Bad frames never reach here
      pend_next   = sh_reg;
      pend_v_next = 1'b1;
      // Fourth word, with buffer full and a word still pending, is reported, not silent
      ovr_next    = pend_v_reg & ~push_s.ready;
      if (sh_reg[SDC_SRR_BIT]) begin
        flag_next = 1'b0;  // Only a good reset request clears
      end
    end
    if (warn) begin
      flag_next = 1'b1;  // Set wins over a clear in the same cycle
    end
  end

  // State registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg  <= SDC_ST_IDLE;
      sh_reg     <= SDC_WORD_RESET;
      cnt_reg    <= SDC_CNT_RESET;
      any_reg    <= 1'b0;
      so_reg     <= 1'b0;
      flag_reg   <= 1'b0;
      cfg_reg    <= SDC_CFG_RESET;
      pend_reg   <= SDC_WORD_RESET;
      pend_v_reg <= 1'b0;
      ovr_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      sh_reg     <= sh_next;
      cnt_reg    <= cnt_next;
      any_reg    <= any_next;
      so_reg     <= so_next;
      flag_reg   <= flag_next;
      cfg_reg    <= cfg_next;
      pend_reg   <= pend_next;
      pend_v_reg <= pend_v_next;
      ovr_reg    <= ovr_next;
    end
  end

  // Pending word waits for room; a word committed while one still waits replaces it
  assign push_s.valid = pend_v_reg;
  assign push_s.data  = pend_reg;
  assign cmd_valid    = pop_s.valid;
  assign cmd_data     = pop_s.data;
  assign pop_s.ready  = cmd_ready;

  sdc_cmd_buffer #(
    .WIDTH (WIDTH)
  ) u_buf (
    .core_clk (core_clk),
    .resetn   (resetn),
    .in_s     (push_s),
    .out_s    (pop_s)
  );

  // Output drives only while selected, so chained outputs can share
  assign sdata_out            = so_reg;
  assign sdata_oe             = (state_reg == SDC_ST_SHIFT);
  assign thermal_warning_flag = flag_reg;
  assign cfg_word             = cfg_reg;
  assign cmd_overrun          = ovr_reg;
endmodule
`default_nettype wire

// File: rtl/sdc_pkg.sv
// Purpose: Shared constants for the daisy-chain serial frame port
// Assumes: Frames of 16-bit words, status and command words sent bit 0 first
// Notes:   Word and counter widths, bit positions and word reset values are named here
`default_nettype none
package sdc_pkg;
  localparam int          SDC_WORD_BITS  = 16;
  localparam int          SDC_CNT_W      = 4;
  localparam int          SDC_WARN_BIT   = 0;  // Status bit 0
  localparam int          SDC_SRR_BIT    = 0;  // Command bit 0
  localparam logic [15:0] SDC_CFG_RESET  = 16'h0000;
  localparam logic [15:0] SDC_WORD_RESET = 16'h0000;
  localparam logic [3:0]  SDC_CNT_RESET  = 4'h0;
  localparam logic [3:0]  SDC_CNT_ONE    = 4'h1;
  localparam int          SDC_BUF_DEPTH  = 2;

  // Frame sequencer states, one-hot
  typedef enum logic [1:0] {
    SDC_ST_IDLE  = 2'b01,
    SDC_ST_SHIFT = 2'b10
  } sdc_state_t;
endpackage
`default_nettype wire

// File: rtl/sdc_stream_if.sv
// Purpose: Valid/ready word stream between the frame port modules
// Assumes: Single clock domain, word taken when valid and ready are high
// Notes:   src drives valid and data, snk drives ready
`timescale 1ns/10ps
`default_nettype none
interface sdc_stream_if #(
  parameter int WIDTH = 16
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: verif/sdc_frame_port_properties.sv
// Purpose: Pin and stream checks for the serial frame port
// Assumes: Pins reach core_clk through two flip-flops
// Notes:   Windows of a few cycles absorb the sync delay
`timescale 1ns/10ps
`default_nettype none
module sdc_frame_port_properties
  import sdc_pkg::*;
#(
  parameter int WIDTH = SDC_WORD_BITS
) (
  input wire logic             core_clk,
  input wire logic             resetn,
  input wire logic             select_bar_in,
  input wire logic             sclk_in,
  input wire logic             sdata_in,
  input wire logic             sdata_out,
  input wire logic             sdata_oe,
  input wire logic             warn_level_in,
  input wire logic [WIDTH-1:0] diag_status_in,
  input wire logic             thermal_warning_flag,
  input wire logic [WIDTH-1:0] cfg_word,
  input wire logic             cmd_valid,
  input wire logic             cmd_ready,
  input wire logic [WIDTH-1:0] cmd_data,
  input wire logic             cmd_overrun
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Select handling and the early warning bit
  AST_OE_IDLE: assert property (
    select_bar_in [*6] |-> !sdata_oe && !sdata_out) else $error("idle out");
  AST_OE_ON: assert property (
    $fell(select_bar_in) |-> ##[1:6] sdata_oe) else $error("no enable");
  AST_EARLY: assert property (
    $fell(select_bar_in) ##1 (!select_bar_in && !sclk_in) [*6]
    |-> sdata_out == thermal_warning_flag) else $error("early bit");
  // Stored command moves only once a frame has closed
  AST_CFG_HOLD: assert property (
    !select_bar_in [*6] |-> $stable(cfg_word)) else $error("cfg moved");
  AST_CFG_WHEN: assert property (
    $changed(cfg_word) |-> select_bar_in && $past(select_bar_in, 2))
    else $error("cfg early");
  // Warning latch set and clear
  AST_FLAG_CLR: assert property (
    $fell(thermal_warning_flag) |-> cfg_word[SDC_SRR_BIT])
    else $error("flag clear");
  AST_FLAG_SET: assert property (
    warn_level_in [*5] |-> thermal_warning_flag) else $error("flag set");
  // Stalled head must not change, or a word is lost
  AST_CMD_HOLD: assert property (
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
    else $error("cmd moved");
endmodule

bind sdc_frame_port sdc_frame_port_properties #(.WIDTH(WIDTH))
  sdc_frame_port_properties_inst (.core_clk, .resetn, .select_bar_in,
  .sclk_in, .sdata_in, .sdata_out, .sdata_oe, .warn_level_in,
  .diag_status_in, .thermal_warning_flag, .cfg_word, .cmd_valid,
  .cmd_ready, .cmd_data, .cmd_overrun);
`default_nettype wire

// File: verif/sdc_master_model.sv
// Purpose: Serial bus master model for the frame port pins
// Assumes: Pins move on core_clk falling edges, 80 ns half period
// Notes:   Returns at select rise; caller owns the gap between frames
`timescale 1ns/10ps
`default_nettype none
module sdc_master_model (
  input  wire logic core_clk,
  input  wire logic sdata_out,
  output logic      select_bar_in,
  output logic      sclk_in,
  output logic      sdata_in
);
  // Released pins sit at their pull levels
  initial begin
    select_bar_in = 1'b1;
    sclk_in       = 1'b0;
    sdata_in      = 1'b0;
  end

  // LSB first; slow stalls before the first clock
  task automatic frame(input logic [31:0] tx, input int n, input logic sel,
                       input int slow, output logic [31:0] rx);
    rx = '0;
    select_bar_in = !sel;
    repeat (8 + slow) @(negedge core_clk);
    for (int i = 0; i < n; i++) begin
      sdata_in = tx[i];
      repeat (8) @(negedge core_clk);  // Data settles before the rise
      rx[i] = sdata_out;
      sclk_in = 1'b1;
      repeat (8) @(negedge core_clk);
      sclk_in = 1'b0;
    end
    repeat (8) @(negedge core_clk);
    select_bar_in = 1'b1;
    sdata_in = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verif/spi_daisy_chain_frame_port_test.sv
// Purpose: Self-checking bench for the serial frame port
// Assumes: Master model clocks the link at 160 ns, LSB first
// Notes:   Bad-length and deselected frames mix with random ones
`timescale 1ns/10ps
`default_nettype none
module spi_daisy_chain_frame_port_test;
  logic        core_clk, resetn, select_bar_in, sclk_in, sdata_in;
  logic        sdata_out, sdata_oe, warn_level_in, thermal_warning_flag;
  logic        cmd_valid, cmd_ready, cmd_overrun, hold, flag_exp;
  logic [15:0] diag_status_in, cfg_word, cmd_data, cfg_exp;
  logic [15:0] q[$];
  logic [31:0] seed = 32'hc748_7846;
  int          errors, check_count, cycles, ovr_seen, ovr_exp;

  sdc_frame_port sdc_frame_port_inst (.core_clk, .resetn, .select_bar_in,
    .sclk_in, .sdata_in, .sdata_out, .sdata_oe, .warn_level_in,
    .diag_status_in, .thermal_warning_flag, .cfg_word, .cmd_valid,
    .cmd_ready, .cmd_data, .cmd_overrun);
  sdc_master_model sdc_master_model_inst (.core_clk, .sdata_out,
    .select_bar_in, .sclk_in, .sdata_in);

  // Clock and a randomly stalling consumer
  always #5 core_clk = !core_clk;
  // Counter bit bounds each stall, so the queue always drains at the end
  always @(negedge core_clk) cmd_ready <= !hold && (seed[3] || cycles[2]);

  function logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [15:0] status_exp(logic [15:0] d, logic f);
    return {d[15:1], f};
  endfunction
  function automatic logic [15:0] cmd_of(logic [31:0] tx, int n);
    return tx[n-16 +: 16];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Sensor pulse; the latch must outlive it
  task automatic warn_pulse();
    warn_level_in = 1'b1;
    repeat (6) @(negedge core_clk);
    warn_level_in = 1'b0;
    flag_exp = 1'b1;
  endtask

  // One frame, then status, pass-through, command and latch checks
  task automatic run(input logic [31:0] tx, input int n, input logic sel);
    logic [31:0] rx;
    void'(lfsr());
    diag_status_in = seed[15:0];
    sdc_master_model_inst.frame(tx, n, sel, int'(seed[20:16]), rx);
    if (sel && n > 0) check(rx[0], flag_exp);
    if (sel && n > 15)
      check(rx[15:0], status_exp(seed[15:0], flag_exp));
    if (!sel) check(rx, 32'h0000_0000);
    if (sel && n == 32) check(rx[31:16], tx[15:0]);
    if (sel && n > 0 && n % 16 == 0) begin
      cfg_exp = cmd_of(tx, n);
      if (cfg_exp[0]) flag_exp = 1'b0;
      ovr_exp += int'(q.size() == 3);
      if (q.size() == 3) q[2] = cfg_exp;
      else q.push_back(cfg_exp);
    end
    repeat (10) @(negedge core_clk);
    check(cfg_word, cfg_exp);
    check(thermal_warning_flag, flag_exp);
    check(sdata_oe, 1'b0);
  endtask

  // Popped words, overrun pulses and the cycle ceiling
  always @(posedge core_clk) begin
    cycles++;
    if (cmd_overrun === 1'b1) ovr_seen++;
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
      check(cmd_data, q.size() > 0 ? q.pop_front() : 16'hxxxx);
    if (cycles == 40000) begin
      errors++;
      end_sim();
    end
  end

  // Reset, directed corners, a full buffer, then random frames
  initial begin
    core_clk       = 1'b0;
    resetn         = 1'b0;
    warn_level_in  = 1'b0;
    diag_status_in = 16'h0000;
    cmd_ready      = 1'b0;
    hold           = 1'b0;
    flag_exp       = 1'b0;
    cfg_exp        = 16'h0000;
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    run(32'h0000_0000, 16, 1'b1);
    warn_pulse();
    run(32'h0000_0000, 32, 1'b1);
    run(32'h0000_0001, 15, 1'b1);
    run(32'h0000_0001, 16, 1'b0);
    run(32'h0001_0000, 32, 1'b1);
    hold = 1'b1;
    repeat (4) run(lfsr(), 16, 1'b1);
    hold = 1'b0;
    repeat (40) @(negedge core_clk);
    repeat (20) begin
      if (lfsr() % 4 == 0) warn_pulse();
      void'(lfsr());
      run(seed, seed[1] ? int'(seed[8:4]) : 16 + 16 * int'(seed[2]), 1'b1);
    end
    repeat (40) @(negedge core_clk);
    check(q.size(), 0);
    check(ovr_seen, ovr_exp);
    end_sim();
  end
endmodule
`default_nettype wire
